// ---- rtl/lcc_pkg.sv ----
// Constants, register map and types of the logic cell cluster.
`default_nettype none
package lcc_pkg;

    // Geometry of the cluster.
    localparam int CELLS = 16;
    localparam int DATA_INS = 4;
    localparam int ROW_LINES = 6;
    localparam int CTRLS = 8;
    localparam int SRC_W = 3;
    localparam int NONGLOBAL_MAX = 4;
    localparam int CTRL_MAX = 8;

    // Bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CELL_CFG = 8'h00;
    localparam logic [7:0] ADDR_CELL_CFG_LAST = 8'h3C;
    localparam logic [7:0] ADDR_CLUSTER_CTRL = 8'h40;
    localparam logic [7:0] ADDR_CTRL_SRC = 8'h44;
    localparam logic [7:0] ADDR_STATUS = 8'h48;
    localparam logic [7:0] ADDR_CELL_OUT = 8'h4C;

    // Index of each cluster control inside the source select register.
    localparam int CTL_CLK1 = 0;
    localparam int CTL_CLK2 = 1;
    localparam int CTL_CE1 = 2;
    localparam int CTL_CE2 = 3;
    localparam int CTL_CLR1 = 4;
    localparam int CTL_CLR2 = 5;
    localparam int CTL_SCLR = 6;
    localparam int CTL_SLOAD = 7;

    // Source codes: 0 to 5 pick a row clock line.
    localparam logic [2:0] SRC_LOCAL = 3'h6;
    localparam logic [2:0] SRC_OFF = 3'h7;
    // Value of a control whose source is off: enables stay on.
    localparam logic [7:0] CTRL_IDLE = 8'h0C;

    // Cluster control bits.
    localparam int CC_CHIP_RST_EN = 0;
    localparam int CC_CLK2_INV = 1;

    // Status bits.
    localparam int ST_PACK_SLOAD = 0;
    localparam int ST_NONGLOBAL = 1;
    localparam int ST_OVERUSE = 2;

    // Reset values.
    localparam logic [31:0] CELL_CFG_RST = 32'h0000_0000;
    localparam logic [1:0] CLUSTER_CTRL_RST = 2'h0;
    localparam logic [23:0] CTRL_SRC_RST = 24'hFF_FFFF;

    // Clear selection codes of a cell.
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_ONE = 2'h1;
    localparam logic [1:0] CLR_TWO = 2'h2;

    typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} lcc_ff_t;

    // Per-cell configuration word, one bus word per cell.
    typedef struct packed {
        logic [3:0] local_src;
        logic local_en;
        lcc_ff_t ff_type;
        logic preset;
        logic [1:0] clr_sel;
        logic clk_sel;
        logic chain;
        logic packed_reg;
        logic feedback;
        logic cin_sel;
        logic arith;
        logic [15:0] lut_mask;
    } lcc_cell_cfg_t;

endpackage
`default_nettype wire

// ---- rtl/lcc_cluster.sv ----
// Logic cell cluster: sixteen cells, cluster controls and a config port.
//
// Summary of operation
// RULE1: Every cell takes four data inputs, carry-in and register-chain input.
// RULE2: Clocks, clears, sync clear, sync load, enables reach every cell.
// RULE3: Normal mode: four-input table, carry-in or fourth input as one input.
// RULE4: Normal mode allows packed register use and own register feedback.
// RULE5: Arithmetic mode builds a full adder with carry to next cell.
// RULE6: Arithmetic mode: both result outputs, register feedback and packing.
// RULE7: Carry chain leaves through cluster carry-out into the cluster below.
// RULE8: Register chain passes each register output to the next cell register.
// RULE9: Sixteen cells with controls, carry and register chains, local links.
// RULE10: A cell output reaches other cells locally and neighbours directly.
// RULE11: Two clocks, two enables, two async clears, one sync clear, one load.
// RULE12: Register packing and synchronous load cannot be used together.
// RULE13: At most four controls from non-global sources; the rest global.
// RULE14: Sync clear and sync load act on every register at clock edge.
// RULE15: Each cluster clock is gated by its own paired clock enable.
// RULE16: Using both edges of one clock consumes both cluster clocks.
// RULE17: Deasserted clock enable stops its clock; registers hold.
// RULE18: Controls come from six row clock lines and local interconnect.
// RULE19: Async clear only; preset by inverting register data and output.
// RULE20: Enabled chip-wide reset clears all registers above everything.
// RULE21: Each register works as D, T, JK or SR flip-flop.
// RULE22: Priority: chip reset, async clear, sync clear, sync load, capture.
//
// Local design decisions: the address map and register access over Avalon-MM.
`default_nettype none
module lcc_cluster #(
    parameter int CELLS = lcc_pkg::CELLS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [lcc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [lcc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [lcc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [CELLS-1:0][lcc_pkg::DATA_INS-1:0] cell_data,
    input wire logic cluster_carry_in,
    input wire logic register_chain_in,
    input wire logic [lcc_pkg::ROW_LINES-1:0] row_clock,
    input wire logic [lcc_pkg::CTRLS-1:0] local_ctrl,
    input wire logic chip_wide_reset_n,
    output logic [CELLS-1:0] cell_comb_out,
    output logic [CELLS-1:0] cell_reg_out,
    output logic cluster_carry_out,
    output logic register_chain_out
);

    lcc_pkg::lcc_cell_cfg_t cell_cfg_ff [CELLS];
    logic [1:0] cluster_ctrl_ff;
    logic [23:0] ctrl_src_ff;
    logic ack_ff;
    logic [lcc_pkg::DATA_W-1:0] readdata_ff;
    logic [1:0] clk_prev_ff;
    logic [CELLS-1:0] q_ff;

    logic [lcc_pkg::CTRLS-1:0] ctrl;
    logic [1:0] cluster_clk;
    logic [1:0] clk_event;
    logic nonglobal_over;
    logic pack_sload;
    logic chip_rst;
    logic [CELLS:0] carry;
    logic [CELLS:0] chain;
    logic [CELLS-1:0] q_out;
    logic [CELLS-1:0] packed_any;
    logic req;
    logic [lcc_pkg::DATA_W-1:0] nxt_readdata;
    logic [lcc_pkg::DATA_W-1:0] wmask;
    logic [3:0] cell_idx;

    // Resolve each control from a row clock line or a local line.
    always_comb begin
        int unsigned nonglobal;
        logic [2:0] sel;
        nonglobal = 0;
        sel = lcc_pkg::SRC_OFF;
        nonglobal_over = 1'b0;
        for (int k = 0; k < lcc_pkg::CTRLS; k++) begin
            sel = ctrl_src_ff[k*lcc_pkg::SRC_W +: lcc_pkg::SRC_W];
            if (sel < 3'(lcc_pkg::ROW_LINES)) begin
                ctrl[k] = row_clock[sel]; // RULE18
            end else if (sel == lcc_pkg::SRC_LOCAL) begin
                nonglobal = nonglobal + 1;
                // Local sources past the allowed count are ignored.
                if (nonglobal > lcc_pkg::NONGLOBAL_MAX) begin
                    ctrl[k] = lcc_pkg::CTRL_IDLE[k]; // RULE13
                    nonglobal_over = 1'b1; // RULE13
                end else begin
                    ctrl[k] = local_ctrl[k]; // RULE18
                end
            end else begin
                ctrl[k] = lcc_pkg::CTRL_IDLE[k];
            end
        end
    end

    // Second clock may carry the inverse of the first for falling edges.
    always_comb begin
        cluster_clk[0] = ctrl[lcc_pkg::CTL_CLK1];
        if (cluster_ctrl_ff[lcc_pkg::CC_CLK2_INV]) begin
            cluster_clk[1] = ~ctrl[lcc_pkg::CTL_CLK1]; // RULE16
        end else begin
            cluster_clk[1] = ctrl[lcc_pkg::CTL_CLK2];
        end
    end

    // Previous clock levels, used to find rising edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_ff <= 2'h0;
        end else begin
            clk_prev_ff <= cluster_clk;
        end
    end

    // Each cluster clock edge counts only while its own enable is high.
    assign clk_event[0] = cluster_clk[0] & ~clk_prev_ff[0]
        & ctrl[lcc_pkg::CTL_CE1]; // RULE15 RULE17
    assign clk_event[1] = cluster_clk[1] & ~clk_prev_ff[1]
        & ctrl[lcc_pkg::CTL_CE2]; // RULE15 RULE17

    assign chip_rst = cluster_ctrl_ff[lcc_pkg::CC_CHIP_RST_EN]
        & ~chip_wide_reset_n; // RULE20
    assign pack_sload = (|packed_any) & ctrl[lcc_pkg::CTL_SLOAD]; // RULE12

    assign carry[0] = cluster_carry_in;
    assign chain[0] = register_chain_in;
    assign cluster_carry_out = carry[CELLS]; // RULE7
    assign register_chain_out = chain[CELLS]; // RULE8
    assign cell_reg_out = q_out;

    // One logic cell per iteration.
    for (genvar i = 0; i < CELLS; i++) begin : g_cell // RULE9
        lcc_pkg::lcc_cell_cfg_t cfg;
        logic [3:0] lin;
        logic [3:0] d;
        logic [2:0] aidx;
        logic comb;
        logic reg_d;
        logic edge_hit;
        logic clr;
        logic nxt_q;

        assign cfg = cell_cfg_ff[i];
        assign d = cell_data[i]; // RULE1
        assign packed_any[i] = cfg.packed_reg;

        // Table inputs: feedback or local link on input 0, carry on 3.
        always_comb begin
            lin = d;
            if (cfg.feedback) begin
                lin[0] = q_out[i]; // RULE4 RULE6
            end else if (cfg.local_en) begin
                lin[0] = q_out[cfg.local_src]; // RULE10
            end
            if (cfg.cin_sel) begin
                lin[3] = carry[i]; // RULE3
            end
        end

        // Arithmetic mode splits the table: low half sum, high half carry.
        assign aidx = {carry[i], lin[1], lin[0]};
        always_comb begin
            if (cfg.arith) begin
                comb = cfg.lut_mask[{1'b0, aidx}]; // RULE5
                carry[i+1] = cfg.lut_mask[{1'b1, aidx}]; // RULE5
            end else begin
                comb = cfg.lut_mask[lin]; // RULE3
                carry[i+1] = carry[i];
            end
        end
        assign cell_comb_out[i] = comb; // RULE6

        // Register data: chain, packed direct input or table output.
        always_comb begin
            if (cfg.chain) begin
                reg_d = chain[i]; // RULE8
            end else if (cfg.packed_reg) begin
                reg_d = d[3]; // RULE4 RULE6
            end else begin
                reg_d = comb;
            end
        end

        // Preset: stored bit is inverted on the way in and out.
        assign q_out[i] = q_ff[i] ^ cfg.preset; // RULE19
        assign chain[i+1] = q_out[i];

        assign edge_hit = cfg.clk_sel ? clk_event[1] : clk_event[0]; // RULE2
        assign clr = (cfg.clr_sel == lcc_pkg::CLR_ONE
            && ctrl[lcc_pkg::CTL_CLR1])
            || (cfg.clr_sel == lcc_pkg::CLR_TWO
            && ctrl[lcc_pkg::CTL_CLR2]); // RULE11 RULE19

        // Flip-flop type; J or S is the data, K or R is data input 2.
        always_comb begin
            logic dd;
            dd = reg_d ^ cfg.preset; // RULE19
            case (cfg.ff_type) // RULE21
                lcc_pkg::FF_D: nxt_q = dd;
                lcc_pkg::FF_T: nxt_q = q_ff[i] ^ dd;
                lcc_pkg::FF_JK: nxt_q = (dd & ~q_ff[i])
                    | (~d[2] & q_ff[i]);
                lcc_pkg::FF_SR: nxt_q = dd | (~d[2] & q_ff[i]);
                default: nxt_q = q_ff[i];
            endcase
        end

        // Register update in priority order.
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                q_ff[i] <= 1'b0;
            end else if (chip_rst) begin
                q_ff[i] <= 1'b0; // RULE20 RULE22
            end else if (clr) begin
                q_ff[i] <= 1'b0; // RULE22
            end else if (edge_hit) begin
                if (ctrl[lcc_pkg::CTL_SCLR]) begin
                    q_ff[i] <= 1'b0; // RULE14 RULE22
                end else if (ctrl[lcc_pkg::CTL_SLOAD] && !pack_sload) begin
                    q_ff[i] <= d[3] ^ cfg.preset; // RULE12 RULE14
                end else begin
                    q_ff[i] <= nxt_q; // RULE22
                end
            end
        end
    end

    // Avalon slave: every access answers on its second cycle.
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign avs_readdata = readdata_ff;
    assign cell_idx = avs_address[5:2];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // Byte lanes of a write.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb begin
        nxt_readdata = '0;
        if (avs_address <= lcc_pkg::ADDR_CELL_CFG_LAST) begin
            nxt_readdata = cell_cfg_ff[cell_idx];
        end else if (avs_address == lcc_pkg::ADDR_CLUSTER_CTRL) begin
            nxt_readdata[1:0] = cluster_ctrl_ff;
        end else if (avs_address == lcc_pkg::ADDR_CTRL_SRC) begin
            nxt_readdata[23:0] = ctrl_src_ff;
        end else if (avs_address == lcc_pkg::ADDR_STATUS) begin
            nxt_readdata[lcc_pkg::ST_PACK_SLOAD] = pack_sload; // RULE12
            nxt_readdata[lcc_pkg::ST_NONGLOBAL] = nonglobal_over; // RULE13
            nxt_readdata[lcc_pkg::ST_OVERUSE] =
                (lcc_pkg::CTRLS > lcc_pkg::CTRL_MAX); // RULE11
        end else if (avs_address == lcc_pkg::ADDR_CELL_OUT) begin
            nxt_readdata = {cell_comb_out, q_out};
        end
    end

    // Read data is captured in the first cycle and held while answered.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_ff <= '0;
        end else if (avs_read && !ack_ff) begin
            readdata_ff <= nxt_readdata;
        end
    end

    // Cell configuration words.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < CELLS; c++) begin
                cell_cfg_ff[c] <= lcc_pkg::CELL_CFG_RST;
            end
        end else if (avs_write && ack_ff
            && avs_address <= lcc_pkg::ADDR_CELL_CFG_LAST) begin
            cell_cfg_ff[cell_idx] <= (cell_cfg_ff[cell_idx] & ~wmask)
                | (avs_writedata & wmask);
        end
    end

    // Cluster control and control source selection.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cluster_ctrl_ff <= lcc_pkg::CLUSTER_CTRL_RST;
            ctrl_src_ff <= lcc_pkg::CTRL_SRC_RST;
        end else if (avs_write && ack_ff) begin
            if (avs_address == lcc_pkg::ADDR_CLUSTER_CTRL
                && avs_byteenable[0]) begin
                cluster_ctrl_ff <= avs_writedata[1:0];
            end
            if (avs_address == lcc_pkg::ADDR_CTRL_SRC) begin
                ctrl_src_ff <= (ctrl_src_ff & ~wmask[23:0])
                    | (avs_writedata[23:0] & wmask[23:0]);
            end
        end
    end

endmodule // lcc_cluster
`default_nettype wire

// ---- sim/lcc_assertions.sv ----
// Port-level assertions for the logic cell cluster.
`default_nettype none
module lcc_assertions #(
    parameter int CELLS = lcc_pkg::CELLS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [lcc_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [CELLS-1:0][lcc_pkg::DATA_INS-1:0] cell_data,
    input wire logic cluster_carry_in,
    input wire logic [lcc_pkg::ROW_LINES-1:0] row_clock,
    input wire logic [lcc_pkg::CTRLS-1:0] local_ctrl,
    input wire logic chip_wide_reset_n,
    input wire logic [CELLS-1:0] cell_comb_out,
    input wire logic [CELLS-1:0] cell_reg_out,
    input wire logic cluster_carry_out,
    input wire logic register_chain_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // All checks run on the system clock and pause in reset.
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Each access sees exactly one wait state, and none while idle.
    wait_first_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest) else $error("request not held off");
    wait_one_a: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    idle_ready_a: assert property (!(avs_read || avs_write) |->
        !avs_waitrequest) else $error("wait raised while idle");
    read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    // Registers move only on control events; tables follow their inputs.
    chain_out_a: assert property (
        register_chain_out == cell_reg_out[CELLS-1])
        else $error("chain output is not the last register");
    quiet_regs_a: assert property (
        (!avs_write && $stable(row_clock) && $stable(local_ctrl)
        && $stable(chip_wide_reset_n))[*4] |-> $stable(cell_reg_out))
        else $error("register moved without a control event");
    comb_quiet_a: assert property (
        (!avs_write && $stable(cell_data) && $stable(cluster_carry_in)
        && $stable(cell_reg_out))[*2] |->
        $stable(cell_comb_out) && $stable(cluster_carry_out))
        else $error("table output moved with steady inputs");
    reset_zero_a: assert property ($rose(rst_n) |->
        cell_reg_out == '0) else $error("registers not cleared by reset");
endmodule // lcc_assertions
`default_nettype wire

// ---- sim/lcc_fabric_model.sv ----
// Fabric-side model that drives the cluster's data and control lines.
`default_nettype none
module lcc_fabric_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [63:0] data_cmd,
    input wire logic [15:0] line_cmd,
    input wire logic fire,
    output logic [15:0][3:0] cell_data,
    output logic cluster_carry_in,
    output logic register_chain_in,
    output logic [7:0] local_ctrl,
    output logic [5:0] row_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pulse_ff;
    // Lines follow the commands one edge later; row line 0 pulses once, high for two cycles.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {cell_data, local_ctrl, row_clock, pulse_ff} <= '0;
            {cluster_carry_in, register_chain_in} <= 2'h0;
        end else begin
            cell_data <= data_cmd;
            {register_chain_in, cluster_carry_in} <= line_cmd[15:14];
            local_ctrl <= line_cmd[13:6];
            row_clock <= line_cmd[5:0] | {5'h0, |pulse_ff};
            pulse_ff <= fire ? 2'h3 : pulse_ff >> 1;
        end
    end
endmodule // lcc_fabric_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the logic cell cluster and its fabric model.
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_n = 1'b1;
    logic rd = 1'b0, wr = 1'b0, wreq, wait_s, fire = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd_s, rdata, v;
    logic [15:0][3:0] cdat;
    logic cin, chin, cout, chout, crst_n = 1'b1;
    logic [5:0] row;
    logic [7:0] loc;
    logic [15:0] comb, regs, exp_r, cs, line_cmd = 16'h0;
    logic [15:0] msk [16];
    logic [63:0] d, data_cmd = 64'h0;
    logic [31:0] lfsr = 32'h020620C1;
    logic [16:0] s;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    lcc_cluster lcc_cluster_i (.clock(clock), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .cell_data(cdat), .cluster_carry_in(cin),
        .register_chain_in(chin), .row_clock(row), .local_ctrl(loc),
        .chip_wide_reset_n(crst_n), .cell_comb_out(comb),
        .cell_reg_out(regs), .cluster_carry_out(cout),
        .register_chain_out(chout));
    lcc_fabric_model lcc_fabric_model_i (.clock(clock), .rst_n(rst_n),
        .data_cmd(data_cmd), .line_cmd(line_cmd), .fire(fire),
        .cell_data(cdat), .cluster_carry_in(cin), .register_chain_in(chin),
        .local_ctrl(loc), .row_clock(row));
    // Clock, and a cycle ceiling that cuts a hang short.
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    // Bus answers are taken on each falling edge, half a cycle before the rising edge.
    always @(negedge clock) begin
        wait_s = wreq;
        rd_s = rdat;
    end
    function automatic logic [31:0] nxt(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] col(logic [63:0] x, int k);
        for (int i = 0; i < 16; i++)
            col[i] = x[4 * i + k];
    endfunction
    // One bus access; holds the request until the wait state is over.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] dv);
        @(posedge clock);
        adr <= a;
        wdat <= dv;
        wr <= w;
        rd <= !w;
        do @(posedge clock); while (wait_s !== 1'b0);
        rdata = rd_s;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic cfg_all(input logic [31:0] w);
        for (int i = 0; i < 16; i++)
            bus(1'b1, 8'(i * 4), w);
    endtask
    task automatic drive(input logic [63:0] dv, input logic [15:0] l);
        data_cmd <= dv;
        line_cmd <= l;
        repeat (3) @(posedge clock);
    endtask
    // One pulse on row line 0, then time for the register to settle.
    task automatic tick();
        @(posedge clock);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, 8'h44, 32'h0);
        `CHK("src_reset", 32'h00FF_FFFF, rdata)
        bus(1'b0, 8'h50, 32'h0);
        `CHK("unmapped", 32'h0, rdata)
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 16; i++) begin
                lfsr = nxt(lfsr);
                msk[i] = lfsr[15:0];
                cs[i] = lfsr[16];
                bus(1'b1, 8'(i * 4), {14'h0, cs[i], 1'b0, msk[i]});
            end
            lfsr = nxt(lfsr);
            d = {lfsr, nxt(lfsr)};
            drive(d, {1'b0, lfsr[5], 14'h0});
            for (int i = 0; i < 16; i++)
                exp_r[i] = msk[i][{cs[i] ? lfsr[5] : d[4*i+3], d[4*i+:3]}];
            `CHK("table", exp_r, comb)
            `CHK("carry_pass", lfsr[5], cout)
        end
        // Adder across all cells, the first case rippling end to end.
        cfg_all(32'h0001_E896);
        for (int t = 0; t < 5; t++) begin
            lfsr = nxt(lfsr);
            v = (t == 0) ? 32'h0000_FFFF : lfsr;
            d = 64'h0;
            for (int i = 0; i < 16; i++)
                d[4 * i +: 2] = {v[16 + i], v[i]};
            drive(d, {1'b0, t == 0 || lfsr[7], 14'h0});
            s = 17'(v[15:0]) + 17'(v[31:16]) + 17'(t == 0 || lfsr[7]);
            `CHK("sum", s[15:0], comb)
            `CHK("carry_out", s[16], cout)
        end
        // Controls from row lines and local lines, then priorities.
        bus(1'b1, 8'h44, 32'h00DB_EE78);
        cfg_all(32'h0040_AAAA);
        lfsr = nxt(lfsr);
        d = {lfsr, ~lfsr};
        drive(d, 16'h0002);
        tick();
        exp_r = col(d, 0);
        `CHK("capture", exp_r, regs)
        bus(1'b0, 8'h4C, 32'h0);
        `CHK("out_reg", exp_r, rdata[15:0])
        drive(~d, 16'h0000);
        tick();
        `CHK("gated", exp_r, regs)
        drive(d, 16'h3002);
        tick();
        `CHK("sclr_first", 16'h0, regs)
        drive(d, 16'h2002);
        tick();
        `CHK("sload", col(d, 3), regs)
        drive(d, 16'h0402);
        `CHK("aclr", 16'h0, regs)
        tick();
        `CHK("aclr_first", 16'h0, regs)
        drive(d, 16'h0002);
        tick();
        @(posedge clock);
        crst_n <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("chip_off", col(d, 0), regs)
        bus(1'b1, 8'h40, 32'h1);
        repeat (3) @(posedge clock);
        `CHK("chip_on", 16'h0, regs)
        crst_n <= 1'b1;
        bus(1'b1, 8'h40, 32'h0);
        // Shift a random pattern through the register chain.
        cfg_all(32'h0010_0000);
        exp_r = 16'h0;
        for (int t = 0; t < 16; t++) begin
            lfsr = nxt(lfsr);
            drive(d, {lfsr[0], 15'h0002});
            tick();
            exp_r = {exp_r[14:0], lfsr[0]};
        end
        `CHK("shift", exp_r, regs)
        `CHK("chain_out", exp_r[15], chout)
        // Clock two as the inverse of clock one drives toggle registers.
        bus(1'b1, 8'h40, 32'h2);
        cfg_all(32'h0220_AAAA);
        tick();
        `CHK("toggle_fall", exp_r ^ col(d, 0), regs)
        // Preset register fed back inverted: clear shows ones, then toggles.
        cfg_all(32'h0144_5555);
        drive(d, 16'h0402);
        `CHK("preset_clr", 16'hFFFF, regs)
        `CHK("feedback", 16'h0, comb)
        drive(d, 16'h0002);
        tick();
        `CHK("fb_toggle", 16'h0, regs)
        `CHK("fb_comb", 16'hFFFF, comb)
        bus(1'b1, 8'h00, 32'h0008_0000);
        bus(1'b1, 8'h44, 32'h00DB_EE70);
        drive(d, 16'h2000);
        bus(1'b0, 8'h48, 32'h0);
        `CHK("status_four", 32'h1, rdata)
        bus(1'b1, 8'h44, 32'h00DB_6DB6);
        bus(1'b0, 8'h48, 32'h0);
        `CHK("status_many", 32'h2, rdata)
        finish_test();
    end
endmodule // tb_top
bind lcc_cluster lcc_assertions #(.CELLS(CELLS)) lcc_assertions_i (
    .clock(clock), .rst_n(rst_n), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cell_data(cell_data),
    .cluster_carry_in(cluster_carry_in), .row_clock(row_clock),
    .local_ctrl(local_ctrl), .chip_wide_reset_n(chip_wide_reset_n),
    .cell_comb_out(cell_comb_out), .cell_reg_out(cell_reg_out),
    .cluster_carry_out(cluster_carry_out),
    .register_chain_out(register_chain_out));
`default_nettype wire
